// ### hw/fcp_pkg.sv
package fcp_pkg;

  localparam int BYTE_W = 8;
  localparam int MEM_DEPTH = 64;
  localparam int ADDR_W = 6;
  localparam int CNT_W = 7;
  localparam int CLEAR_CYCLES = MEM_DEPTH;
  localparam int CORE_SYNC_W = 6;
  localparam int LINK_SYNC_W = 4;

  // word count at which the next byte is the check byte
  localparam logic [CNT_W-1:0] WORD_END = CNT_W'(MEM_DEPTH);
  localparam logic [CNT_W-1:0] WORD_FIRST = 7'h00;
  localparam logic [ADDR_W-1:0] CLEAR_LAST = ADDR_W'(CLEAR_CYCLES - 1);
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_SEED = 8'h00;

  typedef enum logic [2:0] {
    ST_CLEAR = 3'b000,
    ST_WAIT_INIT = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_LOAD = 3'b011,
    ST_USER = 3'b100,
    ST_CRC_ERR = 3'b101
  } fcp_state_t;

  // bus bit 0 carries the byte's most significant bit
  function automatic logic [BYTE_W-1:0] fcp_bit_rev(
    input logic [BYTE_W-1:0] b
  );
    logic [BYTE_W-1:0] r;
    r = '0;
    for (int i = 0; i < BYTE_W; i++)
    begin
      r[i] = b[BYTE_W-1-i];
    end
    return r;
  endfunction

  function automatic logic [BYTE_W-1:0] fcp_crc8(
    input logic [BYTE_W-1:0] c,
    input logic [BYTE_W-1:0] d
  );
    logic [BYTE_W-1:0] r;
    r = c ^ d;
    for (int i = 0; i < BYTE_W; i++)
    begin
      r = r[BYTE_W-1] ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

endpackage

// ### hw/fcp_sync.sv
`timescale 1ns/1ps
// three-stage synchroniser; a bit changes once stages two and three agree
module fcp_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  wire logic [W-1:0] agree;
  wire logic [W-1:0] next_q;

  assign agree = ~(s2 ^ s3);
  assign next_q = (s3 & agree) | (q & ~agree);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      q <= '0;
    end
    else if (ce)
    begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      q <= next_q;
    end
  end

endmodule

// ### hw/fcp_cfg_mem.sv
`timescale 1ns/1ps
// configuration store, single clock, registered read data
module fcp_cfg_mem (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic we,
  input wire logic [fcp_pkg::ADDR_W-1:0] waddr,
  input wire logic [fcp_pkg::BYTE_W-1:0] wdata,
  input wire logic [fcp_pkg::ADDR_W-1:0] raddr,
  output logic [fcp_pkg::BYTE_W-1:0] rdata
);

  logic [fcp_pkg::BYTE_W-1:0] mem [fcp_pkg::MEM_DEPTH];

  always_ff @(posedge clk)
  begin
    if (ce && we)
    begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rdata <= '0;
    end
    else if (ce)
    begin
      rdata <= mem[raddr];
    end
  end

endmodule

// ### hw/fcp_config_port.sv
`timescale 1ns/1ps
// Functional notes
// - serial mode takes one data bit per rising configuration clock edge
// - once loaded in serial mode, serial input is forwarded on serial output to next device
// - after reset a 64-cycle clearing phase runs without touching memory, then the init line is released high
// - init line is only ever pulled low, never driven high
// - init held low externally stalls before the mode input is sampled
// - a check byte mismatch pulls the init line low
// - bus bit 0 is the byte's most significant bit, bit 7 the least
// - chip select and write low capture the bus byte on the clock edge
// - write line going high mid-load aborts a byte-wide (parallel) load; serial loads ignore it
// - readback drives one stored byte per clock edge onto the bus
// - after load pins turn to user I/O unless persist is set
// - readback works only in user mode with persist set
module fcp_config_port (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic CE,
  input wire logic CFG_CLK,
  input wire logic PERSIST,
  input wire logic MODE_PARALLEL,
  input wire logic SERIAL_IN,
  output logic SERIAL_OUT,
  input wire logic INIT_IN,
  output logic INIT_OUT,
  output logic INIT_OE_N,
  input wire logic CS_N,
  input wire logic READ_WRITE_N,
  input wire logic [7:0] CFG_BYTE_BUS_IN,
  output logic [7:0] CFG_BYTE_BUS_OUT,
  output logic CFG_BYTE_BUS_OE_N,
  output logic USER_MODE,
  output logic USER_IO_SEL,
  output logic CRC_ERROR
);

  // core side, CLOCK domain
  fcp_pkg::fcp_state_t state;
  fcp_pkg::fcp_state_t next_state;
  logic [fcp_pkg::ADDR_W-1:0] clear_cnt;
  logic mode_par;
  logic arm;
  logic init_low;
  logic user_mode;
  logic user_io;
  logic crc_err;
  wire logic [fcp_pkg::CORE_SYNC_W-1:0] core_in;
  wire logic [fcp_pkg::CORE_SYNC_W-1:0] core_q;
  wire logic init_s;
  wire logic mode_s;
  wire logic persist_s;
  wire logic done_s;
  wire logic err_s;
  wire logic abort_s;

  // link side, CFG_CLK domain
  logic [6:0] shift;
  logic [2:0] bit_cnt;
  logic [fcp_pkg::CNT_W-1:0] word_cnt;
  logic [fcp_pkg::BYTE_W-1:0] crc;
  logic done;
  logic err;
  logic abort;
  logic serial_out;
  logic [fcp_pkg::ADDR_W-1:0] rd_addr;
  wire logic link_rst;
  wire logic [fcp_pkg::LINK_SYNC_W-1:0] link_in;
  wire logic [fcp_pkg::LINK_SYNC_W-1:0] link_q;
  wire logic lce;
  wire logic larm;
  wire logic lpar;
  wire logic lpersist;
  wire logic loading;
  wire logic ser_stb;
  wire logic par_stb;
  wire logic byte_stb;
  wire logic body_stb;
  wire logic crc_stb;
  wire logic abort_hit;
  wire logic rb_active;
  wire logic chain_fwd;
  wire logic [fcp_pkg::BYTE_W-1:0] ser_byte;
  wire logic [fcp_pkg::BYTE_W-1:0] par_byte;
  wire logic [fcp_pkg::BYTE_W-1:0] byte_in;
  wire logic [fcp_pkg::BYTE_W-1:0] mem_rdata;

  // ---------------- core domain ----------------
  assign core_in = {INIT_IN, MODE_PARALLEL, PERSIST, done, err, abort};
  assign {init_s, mode_s, persist_s, done_s, err_s, abort_s} = core_q;

  fcp_sync #(.W(fcp_pkg::CORE_SYNC_W)) u_core_sync (
    .clk(CLOCK),
    .rst(RST),
    .ce(CE),
    .d(core_in),
    .q(core_q)
  );

  always_comb
  begin
    next_state = state;
    unique case (state)
      fcp_pkg::ST_CLEAR:
        if (clear_cnt == fcp_pkg::CLEAR_LAST)
          next_state = fcp_pkg::ST_WAIT_INIT;
      fcp_pkg::ST_WAIT_INIT:
        if (init_s)
          next_state = fcp_pkg::ST_SAMPLE;
      fcp_pkg::ST_SAMPLE:
        if (!(done_s || err_s || abort_s))
          next_state = fcp_pkg::ST_LOAD;
      fcp_pkg::ST_LOAD:
        if (err_s)
          next_state = fcp_pkg::ST_CRC_ERR;
        else if (abort_s)
          next_state = fcp_pkg::ST_CLEAR;
        else if (done_s)
          next_state = fcp_pkg::ST_USER;
      fcp_pkg::ST_USER,
      fcp_pkg::ST_CRC_ERR:
        next_state = state;
      default:
        next_state = fcp_pkg::ST_CLEAR;
    endcase
  end

  // stale content is never read back before a full load overwrites it,
  // so clearing is a timed phase holding the init line low
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      state <= fcp_pkg::ST_CLEAR;
      clear_cnt <= '0;
      mode_par <= 1'b0;
      arm <= 1'b0;
      init_low <= 1'b1;
      user_mode <= 1'b0;
      user_io <= 1'b0;
      crc_err <= 1'b0;
    end
    else if (CE)
    begin
      state <= next_state;
      clear_cnt <= (state == fcp_pkg::ST_CLEAR) ? clear_cnt + 1'b1 : '0;
      if (state == fcp_pkg::ST_SAMPLE)
        mode_par <= mode_s;
      // one cycle after the mode latch, so the link never sees arm first
      arm <= (state == fcp_pkg::ST_LOAD) || (state == fcp_pkg::ST_USER);
      init_low <= (next_state == fcp_pkg::ST_CLEAR)
        || (next_state == fcp_pkg::ST_CRC_ERR);
      user_mode <= next_state == fcp_pkg::ST_USER;
      user_io <= (next_state == fcp_pkg::ST_USER) && !persist_s;
      crc_err <= next_state == fcp_pkg::ST_CRC_ERR;
    end
  end

  // open drain: level is always low, only the enable moves
  assign INIT_OUT = 1'b0;
  assign INIT_OE_N = !init_low;
  assign USER_MODE = user_mode;
  assign USER_IO_SEL = user_io;
  assign CRC_ERROR = crc_err;

  // ---------------- link domain ----------------
  // the link reset trails RST by a few link clocks; keep CFG_CLK running
  fcp_sync #(.W(1)) u_rst_sync (
    .clk(CFG_CLK),
    .rst(1'b0),
    .ce(1'b1),
    .d(RST),
    .q(link_rst)
  );

  assign link_in = {CE, arm, mode_par, PERSIST};
  assign {lce, larm, lpar, lpersist} = link_q;

  fcp_sync #(.W(fcp_pkg::LINK_SYNC_W)) u_link_sync (
    .clk(CFG_CLK),
    .rst(link_rst),
    .ce(1'b1),
    .d(link_in),
    .q(link_q)
  );

  assign loading = larm && !done && !err && !abort;
  assign ser_byte = {shift, SERIAL_IN};
  assign ser_stb = loading && !lpar && (bit_cnt == fcp_pkg::BIT_LAST);
  assign par_byte = fcp_pkg::fcp_bit_rev(CFG_BYTE_BUS_IN);
  assign par_stb = loading && lpar && !CS_N && !READ_WRITE_N;
  assign byte_stb = ser_stb || par_stb;
  assign byte_in = lpar ? par_byte : ser_byte;
  assign body_stb = byte_stb && (word_cnt != fcp_pkg::WORD_END);
  assign crc_stb = byte_stb && (word_cnt == fcp_pkg::WORD_END);
  assign abort_hit = loading && lpar && READ_WRITE_N
    && (word_cnt != fcp_pkg::WORD_FIRST);
  assign rb_active = !CS_N && READ_WRITE_N && done && lpersist;
  assign chain_fwd = done && !lpar;

  always_ff @(posedge CFG_CLK)
  begin
    if (link_rst || !larm)
    begin
      shift <= '0;
      bit_cnt <= '0;
      word_cnt <= '0;
      crc <= fcp_pkg::CRC_SEED;
      done <= 1'b0;
      err <= 1'b0;
      abort <= 1'b0;
    end
    else if (lce)
    begin
      if (loading && !lpar)
      begin
        shift <= ser_byte[6:0];
        bit_cnt <= bit_cnt + 1'b1;
      end
      if (body_stb)
      begin
        word_cnt <= word_cnt + 1'b1;
        crc <= fcp_pkg::fcp_crc8(crc, byte_in);
      end
      if (crc_stb)
      begin
        done <= byte_in == crc;
        err <= byte_in != crc;
      end
      if (abort_hit)
        abort <= 1'b1;
    end
  end

  always_ff @(posedge CFG_CLK)
  begin
    if (link_rst)
    begin
      rd_addr <= '0;
      serial_out <= 1'b1;
    end
    else if (lce)
    begin
      rd_addr <= rb_active ? rd_addr + 1'b1 : '0;
      serial_out <= chain_fwd ? SERIAL_IN : 1'b1;
    end
  end

  fcp_cfg_mem u_mem (
    .clk(CFG_CLK),
    .rst(link_rst),
    .ce(lce),
    .we(body_stb),
    .waddr(word_cnt[fcp_pkg::ADDR_W-1:0]),
    .wdata(byte_in),
    .raddr(rd_addr),
    .rdata(mem_rdata)
  );

  assign SERIAL_OUT = serial_out;
  assign CFG_BYTE_BUS_OUT = fcp_pkg::fcp_bit_rev(mem_rdata);
  assign CFG_BYTE_BUS_OE_N = !rb_active;

  // ---------------- checks, core domain ----------------
  property p_clear_release;
    @(posedge CLOCK) disable iff (RST || !CE)
      $fell(init_low) |-> state == fcp_pkg::ST_WAIT_INIT && INIT_OE_N;
  endproperty
  a_clear_release: assert property (p_clear_release)
    else $error("init released outside the end of clearing");

  property p_open_drain;
    @(posedge CLOCK) disable iff (RST)
      !INIT_OE_N |-> INIT_OUT == 1'b0 && !USER_MODE;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("init line driven other than low or in user mode");

  property p_init_stall;
    @(posedge CLOCK) disable iff (RST || !CE)
      state == fcp_pkg::ST_WAIT_INIT && !init_s
        |=> state == fcp_pkg::ST_WAIT_INIT && !arm;
  endproperty
  a_init_stall: assert property (p_init_stall)
    else $error("configuration started while init held low");

  property p_crc_fault;
    @(posedge CLOCK) disable iff (RST || !CE)
      state == fcp_pkg::ST_LOAD && err_s
        |=> state == fcp_pkg::ST_CRC_ERR && !INIT_OE_N && CRC_ERROR;
  endproperty
  a_crc_fault: assert property (p_crc_fault)
    else $error("check byte error did not pull init low");

  property p_abort_core;
    @(posedge CLOCK) disable iff (RST || !CE)
      state == fcp_pkg::ST_LOAD && abort_s && !err_s
        |=> state == fcp_pkg::ST_CLEAR ##1 !arm;
  endproperty
  a_abort_core: assert property (p_abort_core)
    else $error("aborted load did not restart clearing");

  property p_user_io;
    @(posedge CLOCK) disable iff (RST || !CE)
      USER_IO_SEL |-> USER_MODE && !$past(persist_s);
  endproperty
  a_user_io: assert property (p_user_io)
    else $error("pins handed to user logic with persist set");

  // ---------------- checks, link domain ----------------
  property p_ser_take;
    @(posedge CFG_CLK) disable iff (link_rst || !lce)
      loading && !lpar && bit_cnt != fcp_pkg::BIT_LAST
        |=> shift[0] == $past(SERIAL_IN);
  endproperty
  a_ser_take: assert property (p_ser_take)
    else $error("serial bit not taken on the clock edge");

  property p_chain;
    @(posedge CFG_CLK) disable iff (link_rst || !lce)
      chain_fwd |=> SERIAL_OUT == $past(SERIAL_IN);
  endproperty
  a_chain: assert property (p_chain)
    else $error("loaded device does not forward serial data");

  property p_par_write;
    @(posedge CFG_CLK) disable iff (link_rst || !lce)
      par_stb && word_cnt != fcp_pkg::WORD_END
        |-> body_stb && byte_in[7] == CFG_BYTE_BUS_IN[0]
          && byte_in[0] == CFG_BYTE_BUS_IN[7]
          ##1 word_cnt == $past(word_cnt) + 1'b1;
  endproperty
  a_par_write: assert property (p_par_write)
    else $error("bus byte not captured or bit order wrong");

  property p_abort_link;
    @(posedge CFG_CLK) disable iff (link_rst || !lce)
      abort_hit |=> abort && !done;
  endproperty
  a_abort_link: assert property (p_abort_link)
    else $error("write line release during load did not abort");

  sequence s_rb_two;
    rb_active ##1 rb_active;
  endsequence

  property p_rb_step;
    @(posedge CFG_CLK) disable iff (link_rst || !lce)
      s_rb_two |=> !$past(CFG_BYTE_BUS_OE_N)
        && rd_addr == $past(rd_addr, 2) + 2'd2;
  endproperty
  a_rb_step: assert property (p_rb_step)
    else $error("readback does not step one byte per edge");

  property p_rb_gate;
    @(posedge CFG_CLK) disable iff (link_rst)
      !CFG_BYTE_BUS_OE_N |-> done && lpersist;
  endproperty
  a_rb_gate: assert property (p_rb_gate)
    else $error("readback outside persist user mode");

  property p_bus_hiz;
    @(posedge CFG_CLK) disable iff (link_rst)
      CS_N || !READ_WRITE_N |-> CFG_BYTE_BUS_OE_N;
  endproperty
  a_bus_hiz: assert property (p_bus_hiz)
    else $error("bus driven outside readback");

endmodule

// ### tb/fcp_host_model.sv
`timescale 1ns/1ps
// configuration source; changes its lines, except init_pull, just after a falling link edge
module fcp_host_model (
  input wire logic cfg_clk,
  output logic serial_in,
  output logic cs_n,
  output logic read_write_n,
  output logic [7:0] bus,
  output logic init_pull
);
  initial
  begin
    serial_in = 1'b1;
    cs_n = 1'b1;
    read_write_n = 1'b0;
    bus = 8'h5a;
    init_pull = 1'b0;
  end

  // released lines flip every falling edge so stale data never passes for fresh
  task automatic idle(input int n);
    repeat (n)
    begin
      @(negedge cfg_clk);
      cs_n <= 1'b1;
      read_write_n <= 1'b0;
      serial_in <= ~serial_in;
      bus <= ~bus;
    end
  endtask

  task automatic hold_init(input logic v);
    init_pull = v;
  endtask

  task automatic send(input logic par, input logic [7:0] b);
    @(negedge cfg_clk);
    if (par)
    begin
      cs_n <= 1'b0;
      read_write_n <= 1'b0;
      for (int i = 0; i < 8; i++)
        bus[i] <= b[7 - i];
    end
    else
    begin
      for (int i = 7; i >= 0; i--)
      begin
        serial_in <= b[i];
        if (i > 0)
          @(negedge cfg_clk);
      end
    end
  endtask

  task automatic read_req();
    @(negedge cfg_clk);
    cs_n <= 1'b0;
    read_write_n <= 1'b1;
  endtask
endmodule

// ### tb/fcp_config_port_test.sv
`timescale 1ns/1ps
module fcp_config_port_test;
  typedef struct packed {
    logic par;
    logic persist;
    logic bad;
    logic stall;
    logic exp_user;
    logic exp_iosel;
    logic exp_err;
  } fcp_row_t;
  localparam fcp_row_t ROWS [4] = '{
    '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0},
    '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0},
    '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1},
    '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1}};
  logic clock = 1'b0;
  logic cfg_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic persist = 1'b0;
  logic mode_par = 1'b0;
  logic serial_in, serial_out, init_in, init_out, init_oe_n, init_pull;
  logic cs_n, read_write_n, bus_oe_n, user_mode, user_io_sel, crc_error;
  logic [7:0] host_bus, bus_in, bus_out;
  int mismatches = 0;
  int comparisons = 0;

  // wired-and init line with pull-up; byte bus resolved from both drivers
  assign init_in = (init_oe_n === 1'b0 || init_pull) ? 1'b0 : 1'b1;
  assign bus_in = (bus_oe_n === 1'b0) ? bus_out : host_bus;

  initial
    forever #12.5 clock = ~clock;
  initial
  begin
    #7;
    forever #24 cfg_clk = ~cfg_clk;
  end

  fcp_config_port u_dut (
    .CLOCK(clock),
    .RST(rst),
    .CE(ce),
    .CFG_CLK(cfg_clk),
    .PERSIST(persist),
    .MODE_PARALLEL(mode_par),
    .SERIAL_IN(serial_in),
    .SERIAL_OUT(serial_out),
    .INIT_IN(init_in),
    .INIT_OUT(init_out),
    .INIT_OE_N(init_oe_n),
    .CS_N(cs_n),
    .READ_WRITE_N(read_write_n),
    .CFG_BYTE_BUS_IN(bus_in),
    .CFG_BYTE_BUS_OUT(bus_out),
    .CFG_BYTE_BUS_OE_N(bus_oe_n),
    .USER_MODE(user_mode),
    .USER_IO_SEL(user_io_sel),
    .CRC_ERROR(crc_error)
  );

  fcp_host_model u_host (
    .cfg_clk(cfg_clk),
    .serial_in(serial_in),
    .cs_n(cs_n),
    .read_write_n(read_write_n),
    .bus(host_bus),
    .init_pull(init_pull)
  );

  task automatic check_bit(input string name, input logic e, input logic g);
    comparisons++;
    if (g !== e)
    begin
      mismatches++;
      $display("mismatch %s expected %b seen %b", name, e, g);
    end
  endtask

  task automatic check_byte(input string name, input logic [7:0] e,
                            input logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  function automatic logic sig(input int s);
    return s == 0 ? init_oe_n : (s == 1 ? user_mode : crc_error);
  endfunction

  task automatic wait_sig(input int s, input logic v, input int n);
    for (int i = 0; i < n && sig(s) !== v; i++)
      @(negedge clock);
  endtask

  function automatic logic [7:0] pat(input int i);
    return 8'((i * 37) + 3);
  endfunction

  function automatic logic [7:0] rev(input logic [7:0] b);
    logic [7:0] r;
    for (int i = 0; i < 8; i++)
      r[i] = b[7 - i];
    return r;
  endfunction

  function automatic logic [7:0] crc_next(input logic [7:0] c,
                                          input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    repeat (8)
      r = r[7] ? ({r[6:0], 1'b0} ^ 8'h07) : {r[6:0], 1'b0};
    return r;
  endfunction

  // reset is held 16 cycles: the link side needs five of its own edges
  task automatic start(input logic stall, input logic par, input logic p);
    u_host.idle(2);
    @(negedge clock);
    rst = 1'b1;
    persist = p;
    u_host.hold_init(stall);
    mode_par = stall ? ~par : par;
    repeat (16) @(negedge clock);
    check_bit("init_oe_n", 1'b0, init_oe_n);
    check_bit("user_mode", 1'b0, user_mode);
    check_bit("serial_out", 1'b1, serial_out);
    check_bit("bus_oe_n", 1'b1, bus_oe_n);
    rst = 1'b0;
    repeat (60) @(negedge clock);
    check_bit("init_oe_n", 1'b0, init_oe_n);
    wait_sig(0, 1'b1, 8);
    check_bit("init_oe_n", 1'b1, init_oe_n);
    check_bit("init_out", 1'b0, init_out);
    if (stall)
    begin
      repeat (100) @(negedge clock);
      check_bit("user_mode", 1'b0, user_mode);
      mode_par = par;
      repeat (6) @(negedge clock);
      u_host.hold_init(1'b0);
    end
    // in serial mode every armed link edge takes a bit, so start right at arm
    for (int i = 0; i < 40 && u_dut.larm !== 1'b1; i++)
    begin
      @(posedge cfg_clk);
      #1;
    end
  endtask

  task automatic load(input logic par, input logic bad);
    logic [7:0] crc;
    crc = 8'h00;
    for (int i = 0; i < 64; i++)
    begin
      if (par && i % 16 == 5)
        u_host.idle(1);
      u_host.send(par, pat(i));
      crc = crc_next(crc, pat(i));
    end
    u_host.send(par, crc ^ {7'h00, bad});
    u_host.idle(2);
    wait_sig(bad ? 2 : 1, 1'b1, 40);
    if (bad)
      wait_sig(0, 1'b0, 20);
  endtask

  task automatic readback(input logic ok);
    u_host.read_req();
    #1;
    check_bit("bus_oe_n", ~ok, bus_oe_n);
    for (int k = 0; k < 66 && ok; k++)
    begin
      @(posedge cfg_clk);
      #1;
      check_byte("readback", rev(pat(k % 64)), bus_out);
    end
    u_host.idle(1);
    #1;
    check_bit("bus_oe_n", 1'b1, bus_oe_n);
  endtask

  task automatic chain();
    logic v;
    fork
      u_host.idle(10);
      for (int k = 0; k < 8; k++)
      begin
        @(posedge cfg_clk);
        v = serial_in;
        #1;
        check_bit("serial_out", v, serial_out);
      end
    join
  endtask

  initial
  begin
    foreach (ROWS[r])
    begin
      start(ROWS[r].stall, ROWS[r].par, ROWS[r].persist);
      load(ROWS[r].par, ROWS[r].bad);
      check_bit("user_mode", ROWS[r].exp_user, user_mode);
      check_bit("user_io_sel", ROWS[r].exp_iosel, user_io_sel);
      check_bit("crc_error", ROWS[r].exp_err, crc_error);
      check_bit("init_oe_n", ~ROWS[r].exp_err, init_oe_n);
      if (ROWS[r].exp_user)
        readback(ROWS[r].persist);
      if (ROWS[r].exp_user && !ROWS[r].par)
        chain();
    end
    // write line lifted part way through a byte-wide load
    start(1'b0, 1'b1, 1'b1);
    readback(1'b0);
    for (int i = 0; i < 5; i++)
      u_host.send(1'b1, pat(i));
    u_host.read_req();
    wait_sig(0, 1'b0, 20);
    check_bit("init_oe_n", 1'b0, init_oe_n);
    check_bit("bus_oe_n", 1'b1, bus_oe_n);
    check_bit("user_mode", 1'b0, user_mode);
    // clock enable low freezes the clearing count, so init stays low
    ce = 1'b0;
    repeat (100) @(negedge clock);
    check_bit("init_oe_n", 1'b0, init_oe_n);
    ce = 1'b1;
    u_host.idle(1);
    wait_sig(0, 1'b1, 80);
    check_bit("init_oe_n", 1'b1, init_oe_n);
    give_verdict();
  end

  initial
  begin
    #1000000;
    mismatches++;
    give_verdict();
  end
endmodule
